// [shared/wit_pkg.sv]
// constants of the watchdog / interval timer: map, fields, resets, timing
// assumes a 25 MHz core clock and a separate low-speed oscillator pin
package wit_pkg;

  // apb register map, byte addresses
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] MASK_OFFSET   = 12'h008;

  // watchdog_control_reg fields
  localparam int CLR_LSB  = 4;
  localparam int EN_BIT   = 3;
  localparam int MODE_BIT = 2;
  localparam int INT_LSB  = 0;

  // status / mask fields
  localparam int FLAG_BIT    = 0;
  localparam int RUN_BIT     = 1;
  localparam int PENDING_BIT = 2;

  // values after reset
  localparam logic [3:0] CLR_RESET  = 4'h0;
  localparam logic [1:0] INT_RESET  = 2'h0;
  localparam logic       MODE_RESET = 1'b0;
  localparam logic       EN_RESET   = 1'b0;
  localparam logic       MASK_RESET = 1'b0;

  // mode select values
  localparam logic MODE_WATCHDOG = 1'b0;
  localparam logic MODE_TIMER    = 1'b1;

  // power mode codes on the powerMode input
  localparam logic [2:0] PWR_ACTIVE = 3'h0;
  localparam logic [2:0] PWR_ZERO   = 3'h1;
  localparam logic [2:0] PWR_ONE    = 3'h2;
  localparam logic [2:0] PWR_TWO    = 3'h3;
  localparam logic [2:0] PWR_THREE  = 3'h4;

  // clear key sequence
  localparam logic [3:0] KEY_FIRST  = 4'hA;
  localparam logic [3:0] KEY_SECOND = 4'h5;

  // timeout in oscillator periods per interval code
  localparam logic [15:0] IVL_CODE0 = 16'h8000;
  localparam logic [15:0] IVL_CODE1 = 16'h2000;
  localparam logic [15:0] IVL_CODE2 = 16'h0200;
  localparam logic [15:0] IVL_CODE3 = 16'h0040;

  // timing
  localparam int CORE_CLK_KHZ  = 25000;
  localparam int KEY_WINDOW_NS = 15258;
  localparam int KEY_WINDOW_CYC = (KEY_WINDOW_NS * CORE_CLK_KHZ) / 1000000;
  localparam logic [8:0] KEY_WINDOW = 9'(KEY_WINDOW_CYC);
  localparam logic [2:0] RESET_PULSE_CYC = 3'h4;

endpackage : wit_pkg

// [hw/wit_pin_sync.sv]
// three-flop synchroniser with agreement filter and rising-edge pulse
// assumes the input is asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module wit_pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin side
  input  wire logic pinIn,
  // core side
  output var  logic level,
  output var  logic rise
);
  logic stage1_ff;
  logic stage2_ff;
  logic stage3_ff;
  logic level_ff;
  logic rise_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
      stage3_ff <= 1'b0;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // only an agreed level counts, glitches of one cycle are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
    end else begin
      if (stage2_ff == stage3_ff) begin
        level_ff <= stage2_ff;
      end
      rise_ff <= (stage2_ff == stage3_ff) && stage2_ff && !level_ff;
    end
  end

  assign level = level_ff;
  assign rise  = rise_ff;
endmodule : wit_pin_sync
`default_nettype wire

// [hw/wit_clear_key.sv]
// two-step clear key detector for watchdog mode
// assumes keyWrite is a one-cycle pulse from the register write path
`timescale 1ns/1ns
`default_nettype none
module wit_clear_key
  import wit_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // key writes
  input  wire logic       keyWrite,
  input  wire logic [3:0] keyValue,
  // result
  output var  logic       keyClear
);
  typedef enum logic {KEY_IDLE, KEY_ARMED} wit_key_state_t;

  wit_key_state_t state_ff;
  logic [8:0]     window_ff;
  logic           keyClear_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= KEY_IDLE;
      window_ff   <= '0;
      keyClear_ff <= 1'b0;
    end else begin
      keyClear_ff <= 1'b0;
      unique case (state_ff)
        KEY_IDLE: begin
          if (keyWrite && keyValue == KEY_FIRST) begin
            state_ff  <= KEY_ARMED;
            window_ff <= KEY_WINDOW;
          end
        end
        KEY_ARMED: begin
          // the window running out cancels the sequence, a wrong write too unless it is KEY_FIRST, which re-arms the window
          if (keyWrite) begin
            keyClear_ff <= (keyValue == KEY_SECOND);
            state_ff    <= (keyValue == KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
            window_ff   <= KEY_WINDOW;
          end else if (window_ff == 9'h001) begin
            state_ff <= KEY_IDLE;
          end else begin
            window_ff <= window_ff - 9'h001;
          end
        end
      endcase
    end
  end

  assign keyClear = keyClear_ff;
endmodule : wit_clear_key
`default_nettype wire

// [hw/wit_watchdog_timer.sv]
// watchdog and interval timer with apb register slave
// assumes lsoClk is a free-running low-speed oscillator, async to core_clk
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module wit_watchdog_timer
  import wit_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // oscillator and power state
  input  wire logic        lsoClk,
  input  wire logic [2:0]  powerMode,
  // chip outputs
  output var  logic        sysReset,
  output var  logic        irq
);
  logic [3:0]  ctrlClr_ff;
  logic        enable_ff;
  logic        modeSel_ff;
  logic [1:0]  intSel_ff;
  logic        irqFlag_ff;
  logic        irqMask_ff;
  logic [14:0] count_ff;
  logic        pending_ff;
  logic [2:0]  resetCnt_ff;
  logic        sysReset_ff;
  logic        irq_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;

  logic        lsoTick;
  logic        keyClear;
  logic [1:0]  regSel;
  logic        wrEn;
  logic        ctrlWr;
  logic        statusWr;
  logic        maskWr;
  logic        clrAllowed;
  logic        timerClear;
  logic        keyWrite;
  logic        awake;
  logic        deepSleep;
  logic        lightSleep;
  logic        countRun;
  logic [15:0] interval;
  logic        expire;
  logic        wdLock;
  logic        resetTrig;

  // register select: 0 none, 1 ctrl, 2 status, 3 mask
  function automatic logic [1:0] decodeAddr(input logic [11:0] addr);
    unique case (addr)
      CTRL_OFFSET:   decodeAddr = 2'h1;
      STATUS_OFFSET: decodeAddr = 2'h2;
      MASK_OFFSET:   decodeAddr = 2'h3;
      default:       decodeAddr = 2'h0;
    endcase
  endfunction : decodeAddr

  function automatic logic [15:0] intervalOf(input logic [1:0] code);
    unique case (code)
      2'h0: intervalOf = IVL_CODE0;
      2'h1: intervalOf = IVL_CODE1;
      2'h2: intervalOf = IVL_CODE2;
      2'h3: intervalOf = IVL_CODE3;
    endcase
  endfunction : intervalOf

  wit_pin_sync u_lso_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .pinIn (lsoClk),
    .level (),
    .rise  (lsoTick)
  );

  wit_clear_key u_clear_key (
    .clk      (core_clk),
    .rst_n    (rst_n),
    .keyWrite (keyWrite),
    .keyValue (pwdata[CLR_LSB +: 4]),
    .keyClear (keyClear)
  );

  // bus decode, write lands in the access cycle with pready high
  assign regSel     = decodeAddr(paddr);
  assign wrEn       = psel && penable && pwrite && pready_ff;
  assign ctrlWr     = wrEn && (regSel == 2'h1);
  assign statusWr   = wrEn && (regSel == 2'h2);
  assign maskWr     = wrEn && (regSel == 2'h3);
  assign clrAllowed = ctrlWr && enable_ff;
  assign timerClear = clrAllowed && (modeSel_ff == MODE_TIMER)
                      && pwdata[CLR_LSB];
  assign keyWrite   = clrAllowed && (modeSel_ff == MODE_WATCHDOG);
  assign wdLock     = enable_ff && (modeSel_ff == MODE_WATCHDOG);

  assign awake      = (powerMode == PWR_ACTIVE) || (powerMode == PWR_ZERO);
  assign lightSleep = (powerMode == PWR_ONE);
  assign deepSleep  = (powerMode == PWR_TWO) || (powerMode == PWR_THREE);
  assign countRun   = enable_ff && !deepSleep;
  assign interval   = intervalOf(intSel_ff);
  assign expire     = lsoTick && countRun
                      && (({1'b0, count_ff} + 16'h0001) == interval);
  // timer mode is kept out of the reset path entirely
  assign resetTrig  = (modeSel_ff == MODE_WATCHDOG) && awake
                      && ((expire && !keyClear) || pending_ff);

  // control register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlClr_ff <= CLR_RESET;
      enable_ff  <= EN_RESET;
      modeSel_ff <= MODE_RESET;
      intSel_ff  <= INT_RESET;
    end else if (ctrlWr) begin
      intSel_ff <= pwdata[INT_LSB +: 2];
      if (clrAllowed) begin
        ctrlClr_ff <= pwdata[CLR_LSB +: 4];
      end
      if (!wdLock) begin
        enable_ff  <= pwdata[EN_BIT];
        modeSel_ff <= pwdata[MODE_BIT];
      end
    end
  end

  // 15-bit counter, never visible on the bus
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 15'h0000;
    end else if (!countRun) begin
      count_ff <= 15'h0000;
    end else if (timerClear || keyClear) begin
      count_ff <= 15'h0000;
    end else if (expire) begin
      count_ff <= 15'h0000;
    end else if (lsoTick) begin
      count_ff <= count_ff + 15'h0001;
    end
  end

  // expiry while in light sleep is held until the core wakes, dropped if deep sleep or a key clear comes first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_ff <= 1'b0;
    end else if (deepSleep || keyClear || resetTrig) begin
      pending_ff <= 1'b0;
    end else if (expire && lightSleep && modeSel_ff == MODE_WATCHDOG) begin
      pending_ff <= 1'b1;
    end
  end

  // system reset pulse of RESET_PULSE_CYC cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resetCnt_ff <= 3'h0;
      sysReset_ff <= 1'b0;
    end else begin
      if (resetTrig) begin
        resetCnt_ff <= RESET_PULSE_CYC;
      end else if (resetCnt_ff != 3'h0) begin
        resetCnt_ff <= resetCnt_ff - 3'h1;
      end
      sysReset_ff <= resetTrig || (resetCnt_ff > 3'h1);
    end
  end

  // sticky flag, write one to clear, a new expiry wins over the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqFlag_ff <= 1'b0;
    end else if (expire && modeSel_ff == MODE_TIMER) begin
      irqFlag_ff <= 1'b1;
    end else if (statusWr && pwdata[FLAG_BIT]) begin
      irqFlag_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqMask_ff <= MASK_RESET;
      irq_ff     <= 1'b0;
    end else begin
      if (maskWr) begin
        irqMask_ff <= pwdata[FLAG_BIT];
      end
      irq_ff <= irqFlag_ff && irqMask_ff;
    end
  end

  // apb answer: one wait-free access cycle, data latched in setup
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && (regSel == 2'h0);
      if (psel && !penable && !pwrite) begin
        unique case (regSel)
          2'h1: prdata_ff <= {24'h00_0000, ctrlClr_ff, enable_ff,
                              modeSel_ff, intSel_ff};
          2'h2: prdata_ff <= {29'h0000_0000, pending_ff, enable_ff,
                              irqFlag_ff};
          2'h3: prdata_ff <= {31'h0000_0000, irqMask_ff};
          2'h0: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign sysReset = sysReset_ff;
  assign irq      = irq_ff;

  timerNoReset_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (modeSel_ff == MODE_TIMER && resetCnt_ff == 3'h0) |=> !sysReset_ff)
    else $error("reset raised in timer mode");

  wdLockEn_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wdLock && ctrlWr && !pwdata[EN_BIT]) |=> enable_ff && !modeSel_ff)
    else $error("enabled watchdog was stopped");

  clrIgnored_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (ctrlWr && !enable_ff) |=> $stable(ctrlClr_ff))
    else $error("clear field taken while disabled");

  deepZero_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    deepSleep |=> (count_ff == 15'h0000))
    else $error("counter running in deep sleep");

  flagSet_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (expire && modeSel_ff) |=> irqFlag_ff ##1 (irq_ff == irqMask_ff))
    else $error("timer expiry did not flag");

  wdReset_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (expire && !modeSel_ff && awake && !keyClear)
      |=> sysReset_ff [*4] ##1 !sysReset_ff)
    else $error("watchdog timeout reset pulse wrong");

  sleepHold_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (expire && !modeSel_ff && lightSleep && !keyClear)
      |=> pending_ff && !sysReset_ff)
    else $error("light sleep expiry handled wrong");

  intervalTick_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (intSel_ff == 2'h3 && expire) |-> (count_ff == 15'h003F))
    else $error("short interval count wrong");

  disabledZero_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !enable_ff |=> (count_ff == 15'h0000) && !expire)
    else $error("counter moves while disabled");

endmodule : wit_watchdog_timer
`default_nettype wire

// [bench/wit_watchdog_timer_tb.sv]
// directed bench for the watchdog / interval timer over apb
// assumes the oscillator runs free at LP core cycles per period
`timescale 1ns/1ns
`default_nettype none
module wit_watchdog_timer_tb;
  import wit_pkg::*;
  // fast oscillator keeps interval runs short, still far slower than core
  localparam int LP = 12;
  logic        core_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lsoClk;
  logic [2:0]  powerMode;
  logic        sysReset;
  logic        irq;
  logic [31:0] rd;
  logic        se;
  int          err_total;
  int          n_checks;
  int          nRst = 0;
  int          hiLen = 0;
  int          cyc;

  wit_watchdog_timer dut (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .lsoClk    (lsoClk),
    .powerMode (powerMode),
    .sysReset  (sysReset),
    .irq       (irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // odd offset so oscillator edges never line up with core edges
  initial begin
    lsoClk = 1'b0;
    #7;
    forever #(LP * 20) lsoClk = ~lsoClk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // counts reset pulses and their width
  always @(posedge core_clk) begin
    if (sysReset === 1'b1) begin
      hiLen <= hiLen + 1;
    end else if (hiLen != 0) begin
      nRst <= nRst + 1;
      hiLen <= 0;
      chk("reset pulse width", 32'd4, 32'(hiLen));
    end
  end

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cycles

  // entered right after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready seen", 1, pready);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0000_0000, r, e);
    chk(nm, x, r);
  endtask : rdc

  // sel 1 waits on irq, 0 on sysReset; bounded by mx cycles
  task automatic waitFor(input bit sel, input int mx, output int c);
    c = 0;
    while (((sel ? irq : sysReset) !== 1'b1) && c < mx) begin
      @(posedge core_clk);
      c++;
    end
  endtask : waitFor

  task automatic rstPulse;
    rst_n <= 1'b0;
    powerMode <= PWR_ACTIVE;
    cycles(16);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask : rstPulse

  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  initial begin
    #(40 * 40000);
    err_total++;
    report_and_stop();
  end

  initial begin
    logic [1:0] code;
    int         per;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    powerMode = PWR_ACTIVE;
    err_total = 0;
    n_checks = 0;
    rstPulse();
    rdc("control reset", CTRL_OFFSET, 32'h0000_0000);
    rdc("status reset", STATUS_OFFSET, 32'h0000_0000);
    rdc("mask reset", MASK_OFFSET, 32'h0000_0000);
    apb(12'h00C, 1'b0, 32'h0000_0000, rd, se);
    chk("unmapped slverr", 1, se);
    wr(CTRL_OFFSET, 32'h0000_00A7);
    rdc("clear while off", CTRL_OFFSET, 32'h0000_0007);
    // timer mode expiry, two interval codes
    wr(MASK_OFFSET, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      code = i ? 2'h2 : 2'h3;
      per = i ? 512 : 64;
      wr(CTRL_OFFSET, 32'h0000_0004 | 32'(code));
      wr(STATUS_OFFSET, 32'h0000_0001);
      wr(CTRL_OFFSET, 32'h0000_000C | 32'(code));
      waitFor(1, per * LP + 200, cyc);
      chk("expiry time", 1, cyc > (per - 3) * LP && cyc < (per + 3) * LP);
    end
    rdc("flag and run", STATUS_OFFSET, 32'h0000_0003);
    wr(STATUS_OFFSET, 32'h0000_0001);
    cycles(3);
    chk("irq after w1c", 0, irq);
    wr(CTRL_OFFSET, 32'h0000_0007);
    wr(MASK_OFFSET, 32'h0000_0000);
    wr(CTRL_OFFSET, 32'h0000_000F);
    cycles(70 * LP);
    chk("masked irq", 0, irq);
    rdc("masked flag", STATUS_OFFSET, 32'h0000_0003);
    wr(STATUS_OFFSET, 32'h0000_0001);
    wr(MASK_OFFSET, 32'h0000_0001);
    repeat (8) begin
      cycles(30 * LP);
      wr(CTRL_OFFSET, 32'h0000_001F);
    end
    rdc("cleared timer", STATUS_OFFSET, 32'h0000_0002);
    wr(CTRL_OFFSET, 32'h0000_0007);
    cycles(100 * LP);
    rdc("stopped timer", STATUS_OFFSET, 32'h0000_0000);
    wr(CTRL_OFFSET, 32'h0000_000F);
    waitFor(1, 70 * LP, cyc);
    chk("restart at zero", 1, cyc > 60 * LP && cyc < 70 * LP);
    chk("no timer reset", 0, nRst);
    // watchdog timeout in active and lightest mode
    for (int i = 0; i < 2; i++) begin
      rstPulse();
      powerMode <= i ? PWR_ZERO : PWR_ACTIVE;
      wr(CTRL_OFFSET, 32'h0000_000B);
      waitFor(0, 70 * LP, cyc);
      chk("wd timeout", 1, cyc > 60 * LP && cyc < 70 * LP);
      cycles(8);
    end
    chk("wd pulses", 2, nRst);
    rstPulse();
    wr(CTRL_OFFSET, 32'h0000_000B);
    wr(CTRL_OFFSET, 32'h0000_0006);
    rdc("locked control", CTRL_OFFSET, 32'h0000_000A);
    wr(CTRL_OFFSET, 32'h0000_000B);
    repeat (8) begin
      cycles(30 * LP);
      wr(CTRL_OFFSET, 32'h0000_00AB);
      wr(CTRL_OFFSET, 32'h0000_005B);
    end
    chk("keys hold off", 2, nRst);
    // second key past the window must not count
    repeat (2) begin
      wr(CTRL_OFFSET, 32'h0000_00AB);
      cycles(400);
      wr(CTRL_OFFSET, 32'h0000_005B);
    end
    cycles(10);
    chk("late key", 3, nRst);
    // light sleep defers the reset to wake-up
    rstPulse();
    wr(CTRL_OFFSET, 32'h0000_000B);
    powerMode <= PWR_ONE;
    cycles(80 * LP);
    chk("sleep no reset", 3, nRst);
    rdc("pending", STATUS_OFFSET, 32'h0000_0006);
    powerMode <= PWR_ACTIVE;
    waitFor(0, 8, cyc);
    chk("wake reset", 1, cyc < 8);
    cycles(8);
    // deep sleep holds the counter at zero
    powerMode <= PWR_TWO;
    cycles(200 * LP);
    chk("deep no reset", 4, nRst);
    powerMode <= PWR_ACTIVE;
    waitFor(0, 70 * LP, cyc);
    chk("deep restart", 1, cyc > 60 * LP && cyc < 70 * LP);
    cycles(8);
    rdc("config kept", CTRL_OFFSET, 32'h0000_000B);
    report_and_stop();
  end
endmodule : wit_watchdog_timer_tb
`default_nettype wire
